// [common/prc_map.vh]
// register map, field positions, reset values and timing counts of the power/reset/clock sequencer
`ifndef PRC_MAP_VH
`define PRC_MAP_VH

`define PRC_CLK_MHZ          200
`define PRC_BTN_START_US     1000
`define PRC_BTN_START_CYC    31'h30D40
`define PRC_LONG_PRESS_MS    5600
`define PRC_LONG_PRESS_CYC   31'h42C1D800
`define PRC_RST_HOLD_CYC     5'h10

`define PRC_OFS_CTRL         8'h00
`define PRC_OFS_VSET         8'h04
`define PRC_OFS_STATUS       8'h08
`define PRC_OFS_IRQ_STAT     8'h0C
`define PRC_OFS_IRQ_MASK     8'h10
`define PRC_OFS_WDOG         8'h14

`define PRC_CTRL_SHUTDOWN    0
`define PRC_CTRL_MULT_LSB    1
`define PRC_CTRL_MULT_MSB    3
`define PRC_CTRL_PLAY        4
`define PRC_CTRL_FLASH_SEL   5
`define PRC_MULT_RST         3'h0
`define PRC_MULT_MAX         3'h6
`define PRC_MULT_PLAY_MAX    3'h5
`define PRC_FLASH_SEL_RST    1'b1

`define PRC_VSET_CORE_LSB    0
`define PRC_VSET_CORE_MSB    3
`define PRC_VSET_ANA_LSB     4
`define PRC_VSET_ANA_MSB     7
`define PRC_VSET_IO33        8
`define PRC_VSET_CORE_RST    4'h8
`define PRC_VSET_ANA_RST     4'h8
`define PRC_VSET_IO33_RST    1'b0

`define PRC_IRQ_BTN_PRESS    0
`define PRC_IRQ_BTN_RELEASE  1
`define PRC_IRQ_LONG_RST     2
`define PRC_IRQ_WDOG_RST     3
`define PRC_IRQ_CORE_RST     4
`define PRC_IRQ_EXT_RST      5
`define PRC_IRQ_W            6

`define PRC_WDOG_W           24

`endif

// [logic/prc_seq.v]
// power-on, reset and clock-multiplier sequencer with an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
//
// Functional notes
// - one millisecond button press starts regulators
// - regulators stay on after button release
// - press beyond 5.6 seconds forces system reset
// - core supply below threshold holds reset
// - watchdog expiry and external pin reset too
// - resets reload voltage defaults, never power off
// - only software shutdown bit turns regulators off
// - button level readable as status bit
// - multiplier 1.0 to 4.0, half steps
// - USB attached forces 4.0x multiplier
// - playback mode caps multiplier at 3.5x
// - external reset gates clock, powers core down
// - external reset asynchronous, active low, unfiltered
// - I/O voltage defaults to 1.8 V after reset
// - write strobe pin shared with port0_bit11
// - long press reboots like watchdog reset
`include "prc_map.vh"

module prc_seq #(
  parameter [30:0] BTN_START_CYC  = `PRC_BTN_START_CYC,
  parameter [30:0] LONG_PRESS_CYC = `PRC_LONG_PRESS_CYC,
  parameter        WDOG_W         = `PRC_WDOG_W
) (
  input  wire        mclk_in,
  input  wire        arst_n_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  input  wire        power_button_in,
  input  wire        ext_reset_n_in,
  input  wire        core_below_thr_in,
  input  wire        usb_attached_in,
  input  wire        test_mode_in,
  input  wire        flash_write_strobe_in,
  input  wire        port0_bit11_out_in,
  input  wire        port0_bit11_oe_in,
  input  wire        wr_pin_in,
  output wire        wr_pin_out,
  output wire        wr_pin_oe_out,
  output wire        port0_bit11_out,
  output wire        reg_enable_out,
  output wire        sys_rst_n_out,
  output wire        clk_buf_en_out,
  output wire        core_powerdown_out,
  output wire [2:0]  pll_mult_code_out,
  output wire [3:0]  core_vset_out,
  output wire [3:0]  analog_vset_out,
  output wire        io_3v3_sel_out,
  output wire        irq_out
);

  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_WAIT = 2'h1;
  localparam [1:0] PH_DONE = 2'h2;
  localparam [4:0] HOLD_CYC = `PRC_RST_HOLD_CYC;

  // two-flop synchronisers for pin inputs
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  wire       btn_s  = sync2_q[0];
  wire       ext_s  = sync2_q[1];
  wire       core_s = sync2_q[2];
  wire       usb_s  = sync2_q[3];
  wire       test_s = sync2_q[4];

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync1_q <= 5'h02;
      sync2_q <= 5'h02;
    end
    else
    begin
      sync1_q <= {test_mode_in, usb_attached_in, core_below_thr_in, ext_reset_n_in, power_button_in};
      sync2_q <= sync1_q;
    end
  end

  // bus phase tracking: one wait state on every transfer
  // write data is used in the wait cycle, while the master drives hwdata
  reg  [1:0]  ph_q;
  reg  [7:0]  addr_q;
  reg         wr_q;
  wire        take = hsel_in & htrans_in[1] & hready_in;

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ph_q   <= PH_IDLE;
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
    end
    else
    begin
      case (ph_q)
        PH_WAIT: ph_q <= PH_DONE;
        PH_IDLE, PH_DONE:
        begin
          if (take)
          begin
            ph_q   <= PH_WAIT;
            addr_q <= {haddr_in[7:2], 2'b00};
            wr_q   <= hwrite_in;
          end
          else
            ph_q <= PH_IDLE;
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  assign hreadyout_out = (ph_q != PH_WAIT);
  assign hresp_out     = 1'b0;

  wire wr_cyc = (ph_q == PH_WAIT) & wr_q;
  wire rd_cyc = (ph_q == PH_WAIT) & ~wr_q;

  // press timer and reset sources
  // the long-press flag allows one reset per press; a release re-arms it
  // writes landing while the system reset is active are dropped, shutdown included
  // a button still held after shutdown restarts the regulators at once
  reg  [30:0]       press_cnt_q;
  reg               long_done_q;
  reg               reg_on_q;
  reg  [4:0]        hold_cnt_q;
  reg  [WDOG_W-1:0] wdog_load_q;
  reg  [WDOG_W-1:0] wdog_cnt_q;
  reg               btn_prev_q;
  reg               core_prev_q;
  reg               ext_prev_q;
  reg               int_rst_q;

  wire long_hit = btn_s & ~long_done_q & (press_cnt_q >= LONG_PRESS_CYC);
  wire wdog_hit = (wdog_load_q != {WDOG_W{1'b0}}) & (wdog_cnt_q == {{(WDOG_W-1){1'b0}}, 1'b1});
  wire shut_wr  = wr_cyc & ~int_rst_q & (addr_q == `PRC_OFS_CTRL) & hwdata_in[`PRC_CTRL_SHUTDOWN];

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      press_cnt_q <= 31'h0;
      long_done_q <= 1'b0;
      reg_on_q    <= 1'b0;
      hold_cnt_q  <= 5'h00;
      btn_prev_q  <= 1'b0;
      core_prev_q <= 1'b0;
      ext_prev_q  <= 1'b1;
      int_rst_q   <= 1'b1;
    end
    else
    begin
      btn_prev_q  <= btn_s;
      core_prev_q <= core_s;
      ext_prev_q  <= ext_s;
      if (!btn_s)
      begin
        press_cnt_q <= 31'h0;
        long_done_q <= 1'b0;
      end
      else if (press_cnt_q != 31'h7FFFFFFF)
        press_cnt_q <= press_cnt_q + 31'h1;
      if (long_hit)
        long_done_q <= 1'b1;
      if (shut_wr)
        reg_on_q <= 1'b0;
      else if (btn_s && press_cnt_q >= BTN_START_CYC)
        reg_on_q <= 1'b1;
      if (long_hit || wdog_hit)
        hold_cnt_q <= HOLD_CYC;
      else if (hold_cnt_q != 5'h00)
        hold_cnt_q <= hold_cnt_q - 5'h01;
      int_rst_q <= long_hit | wdog_hit | (hold_cnt_q > 5'h01) | core_s | ~ext_s;
    end
  end

  // resets never touch reg_on_q; only supply loss (arst) or shutdown does
  // the external pin acts without the clock; its synchronised copy feeds int_rst_q directly, not hold_cnt_q, and the flags
  assign reg_enable_out     = reg_on_q;
  assign sys_rst_n_out      = ext_reset_n_in & ~int_rst_q;
  assign clk_buf_en_out     = ext_reset_n_in;
  assign core_powerdown_out = ~ext_reset_n_in;

  // software registers except the interrupt mask, reloaded by every system reset
  reg  [2:0] mult_q;
  reg        play_q;
  reg        flash_sel_q;
  reg  [3:0] core_vset_q;
  reg  [3:0] ana_vset_q;
  reg        io33_q;
  reg  [`PRC_IRQ_W-1:0] irq_mask_q;

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mult_q      <= `PRC_MULT_RST;
      play_q      <= 1'b0;
      flash_sel_q <= `PRC_FLASH_SEL_RST;
      core_vset_q <= `PRC_VSET_CORE_RST;
      ana_vset_q  <= `PRC_VSET_ANA_RST;
      io33_q      <= `PRC_VSET_IO33_RST;
      irq_mask_q  <= {`PRC_IRQ_W{1'b0}};
      wdog_load_q <= {WDOG_W{1'b0}};
      wdog_cnt_q  <= {WDOG_W{1'b0}};
    end
    else if (int_rst_q)
    begin
      mult_q      <= `PRC_MULT_RST;
      play_q      <= 1'b0;
      flash_sel_q <= `PRC_FLASH_SEL_RST;
      core_vset_q <= `PRC_VSET_CORE_RST;
      ana_vset_q  <= `PRC_VSET_ANA_RST;
      io33_q      <= `PRC_VSET_IO33_RST;
      wdog_load_q <= {WDOG_W{1'b0}};
      wdog_cnt_q  <= {WDOG_W{1'b0}};
    end
    else
    begin
      if (wr_cyc && addr_q == `PRC_OFS_CTRL)
      begin
        mult_q      <= (hwdata_in[`PRC_CTRL_MULT_MSB:`PRC_CTRL_MULT_LSB] > `PRC_MULT_MAX) ?
                       `PRC_MULT_MAX : hwdata_in[`PRC_CTRL_MULT_MSB:`PRC_CTRL_MULT_LSB];
        play_q      <= hwdata_in[`PRC_CTRL_PLAY];
        flash_sel_q <= hwdata_in[`PRC_CTRL_FLASH_SEL];
      end
      if (wr_cyc && addr_q == `PRC_OFS_VSET)
      begin
        core_vset_q <= hwdata_in[`PRC_VSET_CORE_MSB:`PRC_VSET_CORE_LSB];
        ana_vset_q  <= hwdata_in[`PRC_VSET_ANA_MSB:`PRC_VSET_ANA_LSB];
        io33_q      <= hwdata_in[`PRC_VSET_IO33];
      end
      if (wr_cyc && addr_q == `PRC_OFS_IRQ_MASK)
        irq_mask_q <= hwdata_in[`PRC_IRQ_W-1:0];
      if (wr_cyc && addr_q == `PRC_OFS_WDOG)
      begin
        wdog_load_q <= hwdata_in[WDOG_W-1:0];
        wdog_cnt_q  <= hwdata_in[WDOG_W-1:0];
      end
      else if (wdog_load_q != {WDOG_W{1'b0}})
        wdog_cnt_q <= (wdog_cnt_q == {{(WDOG_W-1){1'b0}}, 1'b1}) ? wdog_load_q :
                      wdog_cnt_q - {{(WDOG_W-1){1'b0}}, 1'b1};
    end
  end

  // effective multiplier: USB forces 4.0x, playback caps at 3.5x
  // registered, so a code change reaches the multiplier pins one cycle later
  wire [2:0] mult_eff = usb_s ? `PRC_MULT_MAX :
                        (play_q && mult_q > `PRC_MULT_PLAY_MAX) ? `PRC_MULT_PLAY_MAX :
                        mult_q;
  reg  [2:0] mult_out_q;

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mult_out_q <= `PRC_MULT_RST;
    else
      mult_out_q <= mult_eff;
  end

  assign pll_mult_code_out = mult_out_q;
  assign core_vset_out     = core_vset_q;
  assign analog_vset_out   = ana_vset_q;
  assign io_3v3_sel_out    = io33_q;

  // shared write strobe / port0_bit11 pin
  assign wr_pin_out      = flash_sel_q ? flash_write_strobe_in : port0_bit11_out_in;
  assign wr_pin_oe_out   = flash_sel_q ? 1'b1 : port0_bit11_oe_in;
  assign port0_bit11_out = wr_pin_in;

  // sticky event flags, cleared by reading; a new event wins over the clear
  reg  [`PRC_IRQ_W-1:0] irq_stat_q;
  wire [`PRC_IRQ_W-1:0] irq_set;
  assign irq_set[`PRC_IRQ_BTN_PRESS]   = btn_s & ~btn_prev_q;
  assign irq_set[`PRC_IRQ_BTN_RELEASE] = ~btn_s & btn_prev_q;
  assign irq_set[`PRC_IRQ_LONG_RST]    = long_hit;
  assign irq_set[`PRC_IRQ_WDOG_RST]    = wdog_hit;
  assign irq_set[`PRC_IRQ_CORE_RST]    = core_s & ~core_prev_q;
  assign irq_set[`PRC_IRQ_EXT_RST]     = ~ext_s & ext_prev_q;
  wire irq_rd = rd_cyc & (addr_q == `PRC_OFS_IRQ_STAT);

  genvar gi;
  generate
    for (gi = 0; gi < `PRC_IRQ_W; gi = gi + 1)
    begin : g_irq
      always @(posedge mclk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          irq_stat_q[gi] <= 1'b0;
        else if (irq_set[gi])
          irq_stat_q[gi] <= 1'b1;
        else if (irq_rd)
          irq_stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // read data, registered in the wait cycle
  // watchdog: a non-zero period counts down to a reset, and that reset clears the period; writing zero stops it
  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `PRC_OFS_CTRL:     rd_mux = {26'h0, flash_sel_q, play_q, mult_q, 1'b0};
      `PRC_OFS_VSET:     rd_mux = {23'h0, io33_q, ana_vset_q, core_vset_q};
      `PRC_OFS_STATUS:   rd_mux = {25'h0, test_s, usb_s, mult_out_q, reg_on_q, btn_s};
      `PRC_OFS_IRQ_STAT: rd_mux = {{(32-`PRC_IRQ_W){1'b0}}, irq_stat_q};
      `PRC_OFS_IRQ_MASK: rd_mux = {{(32-`PRC_IRQ_W){1'b0}}, irq_mask_q};
      `PRC_OFS_WDOG:     rd_mux = {{(32-WDOG_W){1'b0}}, wdog_load_q};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hrdata_out <= 32'h00000000;
    else if (rd_cyc)
      hrdata_out <= rd_mux;
  end

endmodule // prc_seq

// [tb/prc_seq_asserts.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`include "prc_map.vh"
module prc_seq_asserts #(
  parameter [30:0] BTN_START_CYC  = 31'h14,
  parameter [30:0] LONG_PRESS_CYC = 31'hC8
) (
  input wire        mclk_in,
  input wire        arst_n_in,
  input wire        hsel_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hwdata_in,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        power_button_in,
  input wire        ext_reset_n_in,
  input wire        core_below_thr_in,
  input wire        usb_attached_in,
  input wire        reg_enable_out,
  input wire        sys_rst_n_out,
  input wire        clk_buf_en_out,
  input wire        core_powerdown_out,
  input wire [2:0]  pll_mult_code_out,
  input wire [3:0]  core_vset_out,
  input wire [3:0]  analog_vset_out,
  input wire        io_3v3_sel_out
);
  logic [11:0] press_q;
  // length of the current unbroken press, saturating
  always @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      press_q <= 12'h0;
    else if (!power_button_in)
      press_q <= 12'h0;
    else if (press_q != 12'hFFF)
      press_q <= press_q + 12'h1;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  chk_bus_wait:
    assert property (hsel_in && htrans_in[1] && hready_in |=> s_wait) else $error("bus wait state wrong");
  chk_okay_resp:
    assert property (hresp_out == 1'b0) else $error("response not okay");
  chk_start_press:
    assert property (press_q == BTN_START_CYC[11:0] + 12'h6 |-> reg_enable_out) else $error("no start");
  chk_stay_on:
    assert property ($fell(reg_enable_out) |-> $past(hsel_in && htrans_in[1] && hwrite_in, 2)
      && $past(hwdata_in[0])) else $error("regulators off without shutdown write");
  chk_long_press:
    assert property (press_q == LONG_PRESS_CYC[11:0] + 12'h4 |-> ##[0:6] !sys_rst_n_out)
      else $error("long press gave no reset");
  chk_core_low:
    assert property (core_below_thr_in [*4] |-> !sys_rst_n_out) else $error("core low gave no reset");
  chk_ext_gate:
    assert property (!ext_reset_n_in |-> !clk_buf_en_out && core_powerdown_out && !sys_rst_n_out)
      else $error("external reset not applied at once");
  chk_reg_kept:
    assert property (reg_enable_out && !sys_rst_n_out |=> reg_enable_out) else $error("reset turned off power");
  chk_vset_dflt:
    assert property ($rose(sys_rst_n_out) |-> core_vset_out == `PRC_VSET_CORE_RST
      && analog_vset_out == `PRC_VSET_ANA_RST && io_3v3_sel_out == `PRC_VSET_IO33_RST)
      else $error("voltages not at defaults after reset");
  chk_mult_range:
    assert property (pll_mult_code_out <= `PRC_MULT_MAX) else $error("multiplier out of range");
  chk_usb_max:
    assert property ((usb_attached_in && sys_rst_n_out) [*5] |-> pll_mult_code_out == `PRC_MULT_MAX)
      else $error("usb multiplier not highest");
endmodule // prc_seq_asserts
bind prc_seq prc_seq_asserts #(.BTN_START_CYC(BTN_START_CYC), .LONG_PRESS_CYC(LONG_PRESS_CYC)) u_prc_seq_asserts (
  .mclk_in, .arst_n_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hwdata_in, .hreadyout_out, .hresp_out,
  .power_button_in, .ext_reset_n_in, .core_below_thr_in, .usb_attached_in, .reg_enable_out, .sys_rst_n_out,
  .clk_buf_en_out, .core_powerdown_out, .pll_mult_code_out, .core_vset_out, .analog_vset_out, .io_3v3_sel_out);

// [tb/prc_btn_model.sv]
// model of the power push button and the external reset source
`timescale 1ns/1ps
module prc_btn_model (
  input  wire  mclk_in,
  output logic power_button_out,
  output logic ext_reset_n_out,
  output logic test_mode_out
);
  initial
  begin
    power_button_out = 1'b0;
    ext_reset_n_out  = 1'b1;
    test_mode_out    = 1'b0; // test mode starts low; set_test drives it
  end
  // button held high for n cycles, then released
  task automatic press(input int n);
    @(posedge mclk_in);
    power_button_out <= 1'b1;
    repeat (n) @(posedge mclk_in);
    power_button_out <= 1'b0;
  endtask
  // test input level, reported in the status register only
  task automatic set_test(input logic v);
    @(posedge mclk_in);
    test_mode_out <= v;
  endtask
  // reset line held low for n cycles, no clock relation needed
  task automatic ext_pulse(input int n);
    @(posedge mclk_in);
    ext_reset_n_out <= 1'b0;
    repeat (n) @(posedge mclk_in);
    ext_reset_n_out <= 1'b1;
  endtask
endmodule // prc_btn_model

// [tb/test_prc_seq.sv]
// self-checking bench of the power, reset and clock sequencer
`timescale 1ns/1ps
module test_prc_seq;
  logic        mclk_in, arst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, power_button_in, ext_reset_n_in;
  logic        core_below_thr_in, usb_attached_in, test_mode_in, flash_write_strobe_in, port0_bit11_out_in;
  logic        port0_bit11_oe_in, wr_pin_in, wr_pin_out, wr_pin_oe_out, port0_bit11_out, reg_enable_out, pin_ext;
  logic        sys_rst_n_out, clk_buf_en_out, core_powerdown_out, io_3v3_sel_out, irq_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in, pll_mult_code_out;
  logic [3:0]  core_vset_out, analog_vset_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  int          fails, samples_checked, rst_seen;
  prc_seq #(.BTN_START_CYC(31'h14), .LONG_PRESS_CYC(31'hC8)) u_prc_seq (
    .mclk_in, .arst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hready_in(hreadyout_out),
    .hwdata_in, .hreadyout_out, .hresp_out, .hrdata_out, .power_button_in, .ext_reset_n_in, .core_below_thr_in,
    .usb_attached_in, .test_mode_in, .flash_write_strobe_in, .port0_bit11_out_in, .port0_bit11_oe_in, .wr_pin_in,
    .wr_pin_out, .wr_pin_oe_out, .port0_bit11_out, .reg_enable_out, .sys_rst_n_out, .clk_buf_en_out,
    .core_powerdown_out, .pll_mult_code_out, .core_vset_out, .analog_vset_out, .io_3v3_sel_out, .irq_out);
  prc_btn_model u_prc_btn_model (.mclk_in, .power_button_out(power_button_in), .ext_reset_n_out(ext_reset_n_in),
    .test_mode_out(test_mode_in));
  assign wr_pin_in = wr_pin_oe_out ? wr_pin_out : pin_ext;
  always @(negedge sys_rst_n_out) if (arst_n_in) rst_seen++;
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial
  begin
    #50us;
    fails++;
    stop_test;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // wait for ready seen high at a rising edge, keep the data in front of that edge
  task automatic rdy_wait(output logic [31:0] r);
    @(negedge mclk_in);
    while (hreadyout_out !== 1'b1) @(negedge mclk_in);
    r = hrdata_out;
    @(posedge mclk_in);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    rdy_wait(r);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    rdy_wait(r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask
  initial
  begin
    arst_n_in = 1'b0;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    htrans_in = 2'h0;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    core_below_thr_in = 1'b0;
    usb_attached_in = 1'b0;
    {port0_bit11_out_in, port0_bit11_oe_in, flash_write_strobe_in, pin_ext, hsize_in} = {4'hF, 3'h2};
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(8'h04, 32'h88, "vset");
    rd(8'h08, 32'h0, "status");
    rd(8'h18, 32'h0, "unmapped");
    wr(8'h10, 32'h3);
    u_prc_btn_model.press(5);
    idle(10);
    chk("short", 32'h0, 32'(reg_enable_out));
    fork
      u_prc_btn_model.press(40);
      begin
        idle(30);
        rd(8'h08, 32'h3, "status_on");
      end
    join
    idle(5);
    chk("kept", 32'h1, 32'(reg_enable_out));
    chk("irq", 32'h1, 32'(irq_out));
    rd(8'h0C, 32'h3, "irq_stat");
    idle(1);
    chk("irq_clr", 32'h0, 32'(irq_out));
    wr(8'h04, 32'h1FF);
    rd(8'h04, 32'h1FF, "vset_wr");
    chk("vset_out", 32'h1FF, {23'h0, io_3v3_sel_out, analog_vset_out, core_vset_out});
    fork
      u_prc_btn_model.ext_pulse(20);
      begin
        idle(2);
        chk("gate", 32'h1, {30'h0, clk_buf_en_out, core_powerdown_out});
        chk("ext_rst", 32'h0, 32'(sys_rst_n_out));
      end
    join
    idle(25);
    rd(8'h04, 32'h88, "vset_rst");
    chk("reg_ext", 32'h1, 32'(reg_enable_out));
    rd(8'h0C, 32'h20, "irq_ext");
    for (int n = 0; n < 8; n++)
    begin
      wr(8'h00, 32'h20 | 32'(n << 1));
      idle(2);
      chk("mult", (n > 6) ? 32'h6 : 32'(n), 32'(pll_mult_code_out));
    end
    wr(8'h00, 32'h3C);
    idle(2);
    chk("play", 32'h5, 32'(pll_mult_code_out));
    u_prc_btn_model.set_test(1'b1);
    @(posedge mclk_in) usb_attached_in <= 1'b1;
    idle(6);
    chk("usb", 32'h6, 32'(pll_mult_code_out));
    rd(8'h08, 32'h7A, "status_usb");
    u_prc_btn_model.set_test(1'b0);
    @(posedge mclk_in) flash_write_strobe_in <= 1'b0;
    idle(1);
    chk("strobe", 32'h0, 32'(wr_pin_out));
    wr(8'h00, 32'h0);
    idle(2);
    chk("gpio", 32'h7, {29'h0, wr_pin_out, wr_pin_oe_out, port0_bit11_out});
    @(posedge mclk_in) {port0_bit11_out_in, port0_bit11_oe_in, pin_ext, usb_attached_in} <= 4'h0;
    idle(2);
    chk("gpio_in", 32'h0, {29'h0, wr_pin_out, wr_pin_oe_out, port0_bit11_out});
    rst_seen = 0;
    wr(8'h14, 32'h0A);
    idle(40);
    chk("wdog", 32'h1, 32'(rst_seen));
    chk("reg_wd", 32'h1, 32'(reg_enable_out));
    rd(8'h0C, 32'h8, "irq_wd");
    @(posedge mclk_in) core_below_thr_in <= 1'b1;
    idle(10);
    chk("core", 32'h0, 32'(sys_rst_n_out));
    @(posedge mclk_in) core_below_thr_in <= 1'b0;
    idle(25);
    rd(8'h0C, 32'h10, "irq_core");
    rst_seen = 0;
    u_prc_btn_model.press(150);
    idle(5);
    u_prc_btn_model.press(150);
    idle(5);
    chk("broken", 32'h0, 32'(rst_seen));
    u_prc_btn_model.press(240);
    idle(30);
    chk("long", 32'h1, 32'(rst_seen));
    chk("reg_long", 32'h1, 32'(reg_enable_out));
    wr(8'h10, 32'h0);
    chk("masked", 32'h0, 32'(irq_out));
    rd(8'h0C, 32'h7, "irq_long");
    wr(8'h00, 32'h1);
    idle(2);
    chk("off", 32'h0, 32'(reg_enable_out));
    stop_test;
  end
endmodule // test_prc_seq
